// ---- hdl/lcd_init_pkg.sv ----
// constants, field layouts and command codes for the lcd reset/init block
// Functional notes
// [RL1] no-operation command byte changes nothing
// [RL2] low hardware reset enters full initial state
// [RL3] reset: display off, forward, all-on off, scan forward
// [RL4] reset: start line first, indicator address 80h
// [RL5] reset: page and column address zero
// [RL6] reset: column input direction, incrementing segment order
// [RL7] reset: n-line inversion off, count 10000
// [RL8] reset: duty 1/65, scan starts line zero
// [RL9] reset: rmw off, oscillator off, frequency zero
// [RL10] reset: power control register all zero
// [RL11] reset: resistor ratio 100, bias one-ninth
// [RL12] reset: contrast set mode cancelled, contrast 100000
// [RL13] reset: discharge, power save, sensor off
// [RL14] reset: temperature gradient select 000
// [RL15] reset: serial shift register contents discarded
// [RL16] reset: common ordering normal, not comb
// [RL17] reset: multiplier clock select 00
// [RL18] soft reset clears page, column, rmw only
// [RL19] host pulses hardware reset at power-on
// [RL20] host sets power control within 5 ms; the bench never sets it, power_ctl stays 0
// [RL21] host waits over 300 ms to settle; the bench waits 16 clock cycles
// [RL22] host enters power save, then discharges, before off
// [RL23] refresh always issues end-of-rmw command
// [RL24] soft reset leaves display memory untouched
// [RL25] hardware reset low holds defaults, ignores commands
package lcd_init_pkg;

  // command bytes, taken with command_data_select low
  localparam logic [7:0] CMD_NOP        = 8'he3;
  localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
  localparam logic [7:0] CMD_RMW_ENTER  = 8'he0;
  localparam logic [7:0] CMD_RMW_END    = 8'hee;
  localparam logic [7:0] CMD_DISP_OFF   = 8'hae;
  localparam logic [7:0] CMD_DISP_ON    = 8'haf;
  localparam logic [7:0] CMD_PSAVE_OFF  = 8'ha8;
  localparam logic [7:0] CMD_PSAVE_ON   = 8'ha9;
  localparam logic [7:0] CMD_DISCH_OFF  = 8'hea;
  localparam logic [7:0] CMD_DISCH_ON   = 8'heb;
  localparam logic [7:0] CMD_TSENS_OFF  = 8'h68;
  localparam logic [7:0] CMD_TSENS_ON   = 8'h69;
  localparam logic [7:0] CMD_COM_NORMAL = 8'hc4;
  localparam logic [7:0] CMD_COM_COMB   = 8'hc5;
  localparam logic [7:0] CMD_CONTR_MODE = 8'h81;
  localparam logic [7:0] CMD_BIAS_MODE  = 8'h50;
  localparam logic [7:0] CMD_MCLK_MODE  = 8'h55;
  localparam logic [7:0] CMD_PAGE_BASE  = 8'hb0;
  localparam logic [7:0] CMD_TGRAD_BASE = 8'h58;

  // reset values
  localparam logic [7:0] INDICATOR_RST  = 8'h80;
  localparam logic [4:0] NLINE_CNT_RST  = 5'h10;
  localparam logic [2:0] RRATIO_RST     = 3'h4;
  localparam logic [2:0] BIAS_NINTH     = 3'h5;
  localparam logic [5:0] CONTRAST_RST   = 6'h20;
  localparam logic [6:0] DUTY_65        = 7'h41;

  // axi4-lite register offsets
  localparam logic [7:0] REG_CMD        = 8'h00;
  localparam logic [7:0] REG_STATE0     = 8'h04;
  localparam logic [7:0] REG_STATE1     = 8'h08;
  localparam logic [7:0] REG_ADDR       = 8'h0c;
  localparam logic [7:0] REG_SERIAL     = 8'h10;

  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [3:0] {
    MODE_IDLE   = 4'h1,
    MODE_CONTR  = 4'h2,
    MODE_BIAS   = 4'h4,
    MODE_MCLK   = 4'h8
  } cmd_mode_t;

  // full set of settings that the driver holds
  typedef struct packed {
    logic       disp_on;
    logic       reverse;
    logic       all_on;
    logic       com_reverse;
    logic [5:0] start_line;
    logic [7:0] indicator;
    logic [3:0] page;
    logic [7:0] column;
    logic       row_dir;
    logic       adc_rev;
    logic       nline_on;
    logic [4:0] nline_cnt;
    logic [6:0] duty;
    logic [5:0] duty_start;
    logic       rmw;
    logic       osc_on;
    logic [3:0] osc_freq;
    logic [3:0] power_ctl;
    logic [2:0] rratio;
    logic [2:0] bias;
    logic [5:0] contrast;
    logic       discharge;
    logic       psave;
    logic [2:0] tgrad;
    logic       tsensor;
    logic       com_comb;
    logic [1:0] mclk;
  } settings_t;

  localparam settings_t SETTINGS_RST = '{
    disp_on: 1'b0, reverse: 1'b0, all_on: 1'b0, com_reverse: 1'b0,
    start_line: 6'h00, indicator: INDICATOR_RST, page: 4'h0,
    column: 8'h00, row_dir: 1'b0, adc_rev: 1'b0, nline_on: 1'b0,
    nline_cnt: NLINE_CNT_RST, duty: DUTY_65, duty_start: 6'h00,
    rmw: 1'b0, osc_on: 1'b0, osc_freq: 4'h0, power_ctl: 4'h0,
    rratio: RRATIO_RST, bias: BIAS_NINTH, contrast: CONTRAST_RST,
    discharge: 1'b0, psave: 1'b0, tgrad: 3'h0, tsensor: 1'b0,
    com_comb: 1'b0, mclk: 2'h0};

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_out_t;

endpackage : lcd_init_pkg

// ---- hdl/lcd_init_core.sv ----
// reset and command-state logic of the lcd driver, axi4-lite slave
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module lcd_init_core (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     hw_reset_in_n,
  input  wire logic                     ser_clk_en,
  input  wire logic                     ser_bit,
  input  wire logic                     ser_cs_n,
  input  wire logic [7:0]               s_awaddr,
  input  wire logic                     s_awvalid,
  input  wire logic [31:0]              s_wdata,
  input  wire logic [3:0]               s_wstrb,
  input  wire logic                     s_wvalid,
  input  wire logic                     s_bready,
  input  wire logic [7:0]               s_araddr,
  input  wire logic                     s_arvalid,
  input  wire logic                     s_rready,
  output logic                          s_awready,
  output logic                          s_wready,
  output logic                          s_bvalid,
  output logic [1:0]                    s_bresp,
  output logic                          s_arready,
  output logic                          s_rvalid,
  output logic [31:0]                   s_rdata,
  output logic [1:0]                    s_rresp,
  output lcd_init_pkg::settings_t       settings,
  output logic                          cmd_busy
);
  import lcd_init_pkg::*;

  typedef struct packed {
    settings_t   set;
    cmd_mode_t   mode;
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    axi_out_t    axo;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [31:0] read_word(input state_t s,
                                            input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      REG_STATE0: v = {4'h0, s.set.disp_on, s.set.reverse, s.set.all_on,
                       s.set.com_reverse, s.set.start_line, 2'h0,
                       s.set.indicator, s.set.row_dir, s.set.adc_rev,
                       s.set.nline_on, s.set.nline_cnt};
      REG_STATE1: v = {1'b0, s.set.duty, s.set.rmw, s.set.osc_on,
                       s.set.osc_freq, s.set.power_ctl, s.set.rratio,
                       s.set.bias, s.set.contrast, 2'h0};
      REG_ADDR:   v = {5'h00, s.set.tgrad, s.set.tsensor, s.set.com_comb,
                       s.set.mclk, s.set.discharge, s.set.psave,
                       s.set.duty_start, s.set.page, s.set.column};
      REG_SERIAL: v = {20'h00000, s.mode, s.shift};
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_word

  function automatic logic reg_known(input logic [7:0] a);
    return (a == REG_CMD) || (a == REG_STATE0) || (a == REG_STATE1) ||
           (a == REG_ADDR) || (a == REG_SERIAL);
  endfunction : reg_known

  // one command byte with command_data_select low
  function automatic state_t exec_cmd(input state_t s, input logic [7:0] c);
    state_t n;
    n = s;
    unique case (s.mode)
      MODE_CONTR: begin
        n.set.contrast = c[5:0];
        n.mode = MODE_IDLE;
      end
      MODE_BIAS: begin
        // forbidden codes 6 and 7 are dropped, mode still released
        if (c[2:1] != 2'h3) begin
          n.set.bias = c[2:0];
        end
        n.mode = MODE_IDLE;
      end
      MODE_MCLK: begin
        n.set.mclk = c[1:0];
        n.mode = MODE_IDLE;
      end
      default: begin
        if (c == CMD_NOP) begin
          n = s; // see [RL1]
        end else if (c == CMD_SOFT_RESET) begin
          n.set.page = 4'h0; // see [RL18]
          n.set.column = 8'h00; // see [RL18]
          n.set.rmw = 1'b0; // see [RL18]
        end else if (c == CMD_RMW_ENTER) begin
          n.set.rmw = 1'b1;
        end else if (c == CMD_RMW_END) begin
          n.set.rmw = 1'b0;
        end else if (c[7:1] == CMD_DISP_OFF[7:1]) begin
          n.set.disp_on = c[0];
        end else if (c[7:1] == CMD_PSAVE_OFF[7:1]) begin
          n.set.psave = c[0];
        end else if (c[7:1] == CMD_DISCH_OFF[7:1]) begin
          n.set.discharge = c[0];
        end else if (c[7:1] == CMD_TSENS_OFF[7:1]) begin
          n.set.tsensor = c[0];
        end else if (c[7:1] == CMD_COM_NORMAL[7:1]) begin
          n.set.com_comb = c[0];
        end else if (c == CMD_CONTR_MODE) begin
          n.mode = MODE_CONTR;
        end else if (c == CMD_BIAS_MODE) begin
          n.mode = MODE_BIAS;
        end else if (c == CMD_MCLK_MODE) begin
          n.mode = MODE_MCLK;
        end else if (c[7:4] == CMD_PAGE_BASE[7:4]) begin
          n.set.page = c[3:0];
        end else if (c[7:3] == CMD_TGRAD_BASE[7:3]) begin
          n.set.tgrad = c[2:0];
        end
      end
    endcase
    return n;
  endfunction : exec_cmd

  always_comb begin
    st_next = st_reg;
    st_next.axo.awready = 1'b0;
    st_next.axo.wready = 1'b0;
    st_next.axo.arready = 1'b0;
    // bus write: capture address and data in either order
    if (s_awvalid && !st_reg.aw_got && !st_reg.axo.bvalid) begin
      st_next.axo.awready = 1'b1;
    end
    if (st_reg.axo.awready && s_awvalid) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_awaddr;
      st_next.axo.awready = 1'b0;
    end
    if (s_wvalid && !st_reg.w_got && !st_reg.axo.bvalid) begin
      st_next.axo.wready = 1'b1;
    end
    if (st_reg.axo.wready && s_wvalid) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_wdata;
      st_next.w_strb = s_wstrb;
      st_next.axo.wready = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.axo.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.axo.bvalid = 1'b1;
      st_next.axo.bresp = reg_known(st_reg.aw_addr) ? RESP_OKAY
                                                     : RESP_SLVERR;
      // commands ignored while the reset pin is low
      if (st_reg.aw_addr == REG_CMD && st_reg.w_strb[0] &&
          hw_reset_in_n) begin // see [RL25]
        if (!st_reg.w_data[8]) begin
          st_next = exec_cmd(st_next, st_reg.w_data[7:0]);
        end else if (st_reg.set.rmw) begin
          // data write in rmw mode steps only the column
          st_next.set.column = st_reg.set.column + 8'h01;
        end
      end
    end
    if (st_reg.axo.bvalid && s_bready) begin
      st_next.axo.bvalid = 1'b0;
    end
    // bus read
    if (s_arvalid && !st_reg.axo.arready && !st_reg.axo.rvalid) begin
      st_next.axo.arready = 1'b1;
    end
    if (st_reg.axo.arready && s_arvalid) begin
      st_next.axo.arready = 1'b0;
      st_next.axo.rvalid = 1'b1;
      st_next.axo.rdata = read_word(st_reg, s_araddr);
      st_next.axo.rresp = reg_known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_reg.axo.rvalid && s_rready) begin
      st_next.axo.rvalid = 1'b0;
    end
    // serial port: msb first, byte complete on the eighth bit
    if (ser_cs_n) begin
      st_next.bit_cnt = 3'h0;
    end else if (ser_clk_en && hw_reset_in_n) begin
      st_next.shift = {st_reg.shift[6:0], ser_bit};
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      if (st_reg.bit_cnt == 3'h7) begin
        st_next = exec_cmd(st_next, {st_reg.shift[6:0], ser_bit});
      end
    end
    // pin reset: hold every default while low, bus keeps answering
    if (!hw_reset_in_n) begin // see [RL2] [RL25]
      st_next.set = SETTINGS_RST; // see [RL3] [RL4] [RL5] [RL6] [RL7]
      // further defaults: see [RL8] [RL9] [RL10] [RL11] [RL13] [RL14]
      // and ordering/multiplier: see [RL16] [RL17]
      st_next.mode = MODE_IDLE; // see [RL12]
      st_next.shift = 8'h00; // see [RL15]
      st_next.bit_cnt = 3'h0; // see [RL15]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{set: SETTINGS_RST, mode: MODE_IDLE, shift: 8'h00,
                  bit_cnt: 3'h0, aw_got: 1'b0, aw_addr: 8'h00,
                  w_got: 1'b0, w_data: 32'h0000_0000, w_strb: 4'h0,
                  axo: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // no display memory lives here, so soft reset cannot touch it
  assign settings = st_reg.set; // see [RL24]
  assign cmd_busy = (st_reg.mode != MODE_IDLE);
  assign s_awready = st_reg.axo.awready;
  assign s_wready = st_reg.axo.wready;
  assign s_bvalid = st_reg.axo.bvalid;
  assign s_bresp = st_reg.axo.bresp;
  assign s_arready = st_reg.axo.arready;
  assign s_rvalid = st_reg.axo.rvalid;
  assign s_rdata = st_reg.axo.rdata;
  assign s_rresp = st_reg.axo.rresp;

endmodule : lcd_init_core
`default_nettype wire

// ---- sim/lcd_init_sva.sv ----
// assertion checker for the lcd reset and init block
`timescale 1ns/10ps
`default_nettype none
module lcd_init_sva (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    hw_reset_in_n,
  input wire logic [7:0]              s_awaddr,
  input wire logic                    s_awvalid,
  input wire logic [31:0]             s_wdata,
  input wire logic [3:0]              s_wstrb,
  input wire logic                    s_wvalid,
  input wire logic                    s_arvalid,
  input wire logic                    s_awready,
  input wire logic                    s_wready,
  input wire logic                    s_bvalid,
  input wire logic                    s_arready,
  input wire logic                    s_rvalid,
  input wire lcd_init_pkg::settings_t settings,
  input wire logic                    cmd_busy
);
  import lcd_init_pkg::*;
  settings_t s, kept, snap;
  logic      take;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  assign s = settings;
  // a command byte taken while the driver listens
  assign take = s_awvalid && s_awready && s_wvalid && s_wready && !cmd_busy
    && s_awaddr == REG_CMD && s_wstrb[0] && !s_wdata[8] && hw_reset_in_n;
  always_comb begin
    kept = s;
    kept.page = 4'h0;
    kept.column = 8'h00;
    kept.rmw = 1'b0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) snap <= SETTINGS_RST;
    else if (take) snap <= kept;
  end
  property p_hw_look;
    !hw_reset_in_n |=> {s.disp_on, s.reverse, s.all_on, s.com_reverse,
      s.row_dir, s.adc_rev, s.com_comb} == '0;
  endproperty
  a_hw_look: assert property (p_hw_look)
    else $error("display mode not at defaults");
  property p_hw_addr;
    !hw_reset_in_n |=> s.start_line == 0 && s.indicator == INDICATOR_RST
      && s.page == 0 && s.column == 0 && !s.nline_on && s.duty == DUTY_65
      && s.nline_cnt == NLINE_CNT_RST && s.duty_start == 0;
  endproperty
  a_hw_addr: assert property (p_hw_addr)
    else $error("addressing or drive not at defaults");
  property p_hw_supply;
    !hw_reset_in_n |=> {s.rmw, s.osc_on, s.osc_freq, s.power_ctl,
      cmd_busy} == '0 && s.rratio == RRATIO_RST && s.bias == BIAS_NINTH
      && s.contrast == CONTRAST_RST;
  endproperty
  a_hw_supply: assert property (p_hw_supply)
    else $error("supply settings not at defaults");
  property p_hw_power;
    !hw_reset_in_n |=> {s.mclk, s.discharge, s.psave, s.tgrad, s.tsensor}
      == '0;
  endproperty
  a_hw_power: assert property (p_hw_power)
    else $error("power options not at defaults");
  property p_hw_hold;
    !hw_reset_in_n ##1 !hw_reset_in_n |=> $stable(settings);
  endproperty
  a_hw_hold: assert property (p_hw_hold)
    else $error("settings moved while reset pin low");
  property p_nop;
    take && s_wdata[7:0] == CMD_NOP |=> $stable(settings) [*3];
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-operation byte changed settings");
  property p_soft;
    take && s_wdata[7:0] == CMD_SOFT_RESET |-> ##[1:3] s.page == 0
      && s.column == 0 && !s.rmw && kept == snap;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset result wrong");
  property p_wr_lat;
    s_awvalid && s_wvalid && !s_awready && !s_wready && !s_bvalid
      |=> s_awready && s_wready ##1 !s_awready ##1 s_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response timing wrong");
  property p_rd_lat;
    s_arvalid && !s_arready && !s_rvalid |=> s_arready ##1 s_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read response timing wrong");
  c_soft: cover property (take && s_wdata[7:0] == CMD_SOFT_RESET);
  c_busy: cover property ($rose(cmd_busy));
  c_pin: cover property ($fell(hw_reset_in_n));
endmodule : lcd_init_sva
bind lcd_init_core lcd_init_sva u_sva (.clk, .resetn, .hw_reset_in_n,
  .s_awaddr, .s_awvalid, .s_wdata, .s_wstrb, .s_wvalid, .s_arvalid,
  .s_awready, .s_wready, .s_bvalid, .s_arready, .s_rvalid, .settings,
  .cmd_busy);
`default_nettype wire

// ---- sim/lcd_host_model.sv ----
// host side model: reset pin and serial port
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  input  wire logic clk,
  output logic      hw_reset_in_n,
  output logic      ser_clk_en,
  output logic      ser_bit,
  output logic      ser_cs_n
);
  initial begin
    hw_reset_in_n = 1'b0;
    ser_clk_en = 1'b0;
    ser_bit = 1'b0;
    ser_cs_n = 1'b1;
  end
  task automatic hold_reset(input int n);
    hw_reset_in_n <= 1'b0;
    repeat (n) @(posedge clk);
    hw_reset_in_n <= 1'b1;
    ser_cs_n <= 1'b1;
  endtask : hold_reset
  // settle wait scaled far down so the run stays short
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  // leaves a partial byte behind, chip select kept low
  task automatic shift(input int n, input logic [7:0] v);
    ser_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ser_bit <= v[7-i];
      ser_clk_en <= 1'b1;
      @(posedge clk);
      ser_clk_en <= 1'b0;
    end
    // idle line flips so a stale bit is never mistaken
    ser_bit <= ~v[8-n];
  endtask : shift
endmodule : lcd_host_model
`default_nettype wire

// ---- sim/lcd_driver_reset_init_tb.sv ----
// self-checking bench for the lcd reset and init block
`timescale 1ns/10ps
`default_nettype none
module lcd_driver_reset_init_tb;
  import lcd_init_pkg::*;
  logic        clk, resetn, hw_reset_in_n, ser_clk_en, ser_bit, ser_cs_n;
  logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, cmd_busy;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [7:0]  s_awaddr, s_araddr, rc;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  settings_t   settings, e;
  logic [34:0] exp_q[$];
  int          failures, tests_run, cyc;
  lcd_init_core dut (.clk, .resetn, .hw_reset_in_n, .ser_clk_en, .ser_bit,
    .ser_cs_n, .s_awaddr, .s_awvalid, .s_wdata, .s_wstrb, .s_wvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_rready, .s_awready, .s_wready,
    .s_bvalid, .s_bresp, .s_arready, .s_rvalid, .s_rdata, .s_rresp,
    .settings, .cmd_busy);
  lcd_host_model host (.clk, .hw_reset_in_n, .ser_clk_en, .ser_bit,
    .ser_cs_n);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // bit 34 of a note says whether read data is compared
  task automatic cmp(input logic [33:0] g, input logic [34:0] x);
    tests_run++;
    if (!x[34]) g[31:0] = x[31:0];
    if (g !== x[33:0]) begin
      failures++;
      $display("unexpected bus at %0t: got %h exp %h", $time, g, x[33:0]);
    end
  endtask : cmp
  task automatic chk_set(input logic b, input settings_t x);
    tests_run++;
    if ({cmd_busy, settings} !== {b, x}) begin
      failures++;
      $display("unexpected state at %0t: got %h exp %h", $time,
        {cmd_busy, settings}, {b, x});
    end
  endtask : chk_set
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] st, input logic [1:0] r);
    exp_q.push_back({1'b0, r, 32'h0});
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [34:0] x);
    exp_q.push_back(x);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
  endtask : rd
  task automatic cmd(input logic a0, input logic [7:0] b);
    wr(REG_CMD, {23'h0, a0, b}, 4'hf, RESP_OKAY);
  endtask : cmd
  always @(posedge clk) begin
    if (s_bvalid === 1'b1 && s_bready) begin
      cmp({s_bresp, 32'h0}, exp_q.pop_front());
    end
    if (s_rvalid === 1'b1 && s_rready) begin
      cmp({s_rresp, s_rdata}, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    {resetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    failures = 0;
    tests_run = 0;
    cyc = 0;
    rc = 8'($urandom(47258));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    chk_set(1'b0, SETTINGS_RST);
    host.hold_reset(3);
    e = SETTINGS_RST;
    // setup starts a few cycles after release, far inside the limit
    cmd(1'b0, CMD_DISP_ON);
    cmd(1'b0, CMD_TSENS_ON);
    cmd(1'b0, CMD_COM_COMB);
    rc = 8'($urandom % 8);
    cmd(1'b0, CMD_TGRAD_BASE + rc);
    {e.disp_on, e.tsensor, e.com_comb, e.tgrad} = {3'h7, rc[2:0]};
    cmd(1'b0, CMD_CONTR_MODE);
    chk_set(1'b1, e);
    rc = 8'($urandom % 64);
    cmd(1'b0, rc);
    e.contrast = rc[5:0];
    cmd(1'b0, CMD_BIAS_MODE);
    rc = 8'($urandom % 6);
    cmd(1'b0, rc);
    e.bias = rc[2:0];
    cmd(1'b0, CMD_MCLK_MODE);
    rc = 8'($urandom % 3);
    cmd(1'b0, rc);
    e.mclk = rc[1:0];
    // forbidden bias codes release the mode but leave the bias alone
    cmd(1'b0, CMD_BIAS_MODE);
    cmd(1'b0, 8'h06 + 8'($urandom % 2));
    chk_set(1'b0, e);
    host.settle(16);
    rc = 8'($urandom % 9);
    cmd(1'b0, CMD_PAGE_BASE + rc);
    cmd(1'b0, CMD_RMW_ENTER);
    cmd(1'b1, 8'ha5);
    {e.page, e.rmw, e.column} = {rc[3:0], 1'b1, 8'h01};
    cmd(1'b0, CMD_NOP);
    chk_set(1'b0, e);
    cmd(1'b0, CMD_SOFT_RESET);
    {e.page, e.rmw, e.column} = '0;
    chk_set(1'b0, e);
    cmd(1'b0, CMD_RMW_END);
    wr(REG_CMD, {24'h0, CMD_DISP_OFF}, 4'he, RESP_OKAY);
    wr(8'h40, 32'h0, 4'hf, RESP_SLVERR);
    rd(8'h40, {1'b0, RESP_SLVERR, 32'h0});
    chk_set(1'b0, e);
    cmd(1'b0, CMD_PSAVE_ON);
    cmd(1'b0, CMD_DISCH_ON);
    {e.psave, e.discharge} = 2'h3;
    chk_set(1'b0, e);
    cmd(1'b0, CMD_CONTR_MODE);
    // top bits forced high so a cleared shifter is visible
    host.shift(3, 8'($urandom) | 8'he0);
    fork
      host.hold_reset(12);
      begin
        repeat (2) @(posedge clk);
        cmd(1'b0, CMD_DISP_ON);
        chk_set(1'b0, SETTINGS_RST);
      end
    join
    chk_set(1'b0, SETTINGS_RST);
    rd(REG_SERIAL, {1'b1, RESP_OKAY, 20'h0, MODE_IDLE, 8'h00});
    cmd(1'b0, CMD_DISP_ON);
    e = SETTINGS_RST;
    e.disp_on = 1'b1;
    chk_set(1'b0, e);
    complete_run();
  end
endmodule : lcd_driver_reset_init_tb
`default_nettype wire
